//--- dio_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module dio_checker #(
   parameter int BOOT_CYC = 20
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Watched ports
   input wire logic [5:0] emcy_fault_i,
   input wire dio_pkg::dio_emcy_type emcy_msg_o,
   input wire logic emcy_valid_o,
   input wire logic led_ready_o
);
   int up_cnt;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Cycles since reset release, saturating
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         up_cnt <= 0;
      end else if (up_cnt < BOOT_CYC) begin
         up_cnt <= up_cnt + 1;
      end
   end

   a_emcy_code: assert property (
      emcy_valid_o && emcy_msg_o.code != 16'h0000 |->
      emcy_msg_o.code == ((emcy_msg_o.diag[15:8] == 8'h06) ?
      16'h4001 : {8'h30, emcy_msg_o.diag[15:8]}))
      else $error("code does not match source");
   a_errreg_set: assert property (
      emcy_valid_o |->
      (emcy_msg_o.code != 16'h4001 || emcy_msg_o.err_reg[4]) &&
      (emcy_msg_o.code[15:8] != 8'h30 || emcy_msg_o.err_reg[2]))
      else $error("error register bit missing");
   a_clear_temp: assert property (
      emcy_valid_o && emcy_msg_o.code == 16'h0000 &&
      emcy_msg_o.diag[15:8] == 8'h06 |-> !emcy_msg_o.err_reg[4])
      else $error("cleared fault keeps register bit");
   a_diag_form: assert property (
      emcy_valid_o |-> emcy_msg_o.diag[7:0] == 8'h00 &&
      emcy_msg_o.diag[39:16] == 24'h00_0000 &&
      emcy_msg_o.diag[15:8] >= 8'h01 && emcy_msg_o.diag[15:8] <= 8'h06)
      else $error("diagnostic bytes malformed");
   a_rise_send: assert property (
      $rose(emcy_fault_i[0]) |->
      ##[1:2] (emcy_valid_o && emcy_msg_o.code == 16'h3001))
      else $error("no message on fault onset");
   a_fall_send: assert property (
      $fell(emcy_fault_i[0]) |-> ##[1:2] (emcy_valid_o &&
      emcy_msg_o.code == 16'h0000 && emcy_msg_o.diag[15:8] == 8'h01))
      else $error("no message on fault release");
   a_no_repeat: assert property (
      $stable(emcy_fault_i) [*8] |=> !emcy_valid_o)
      else $error("message without fault change");
   a_boot_dark: assert property (
      up_cnt < BOOT_CYC - 1 |-> !led_ready_o)
      else $error("ready lit before boot ends");
endmodule

`default_nettype wire

//--- dio_defines.svh
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// Register byte offsets
`define DIO_REG_INPUT 8'h00
`define DIO_REG_OUTPUT 8'h04
`define DIO_REG_IOSTAT 8'h08
`define DIO_REG_CTRL 8'h0C
`define DIO_REG_STATUS 8'h10
`define DIO_REG_SAFE 8'h14
`define DIO_REG_OUT_DLY 8'h18
`define DIO_REG_IN_DLY 8'h1C
`define DIO_REG_RESTORE 8'h20
`define DIO_REG_FW_DATA 8'h24
`define DIO_REG_FW_COUNT 8'h28
`define DIO_REG_IRQ_STAT 8'h2C
`define DIO_REG_IRQ_MASK 8'h30
`define DIO_REG_EMCY_LO 8'h34
`define DIO_REG_EMCY_HI 8'h38

// Control bit positions
`define DIO_CTRL_DC_REQ 0
`define DIO_CTRL_RESTART 1
`define DIO_CTRL_BUS_OP 2

// Interrupt bit positions
`define DIO_IRQ_EMCY 0
`define DIO_IRQ_WDOG 1
`define DIO_IRQ_APPLY 2

// Emergency codes and contents
`define DIO_EMCY_SUPPLY_BASE 16'h3000
`define DIO_EMCY_TEMP 16'h4001
`define DIO_EMCY_CLEAR 16'h0000
`define DIO_ERRREG_SUPPLY 2
`define DIO_ERRREG_TEMP 4
`define DIO_RESTORE_KEY 32'h0000_0001

// Reset values
`define DIO_SAFE_RST 4'h0
`define DIO_DLY_RST 16'h0000

// Timing, in their own units, and the clock period
`define DIO_CLK_NS 10
`define DIO_FREE_CYCLE_NS 1000
`define DIO_WDOG_MS 100
`define DIO_BOOT_MS 50
`define DIO_BLINK_MS 200

`endif

//--- dio_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module dio_master_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Emergency stream from the slave
   input wire dio_pkg::dio_emcy_type msg_i,
   input wire logic valid_i,
   // Collected view
   output dio_pkg::dio_emcy_type last_o,
   output logic [7:0] count_o
);
   // Take each message as it comes; no confirmation path exists
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_o <= '0;
         count_o <= 8'h00;
      end else if (valid_i) begin
         last_o <= msg_i;
         count_o <= count_o + 8'h01;
      end
   end
endmodule

`default_nettype wire

//--- dio_pkg.sv
package dio_pkg;

   // Update timing of the I/O image
   typedef enum logic {
      DIO_MODE_SM,
      DIO_MODE_DC
   } dio_mode_type;

   // Emergency message, least significant byte first
   typedef struct packed {
      logic [39:0] diag;
      logic [7:0] err_reg;
      logic [15:0] code;
   } dio_emcy_type;

   // Fault supervision inputs feeding the status word
   typedef struct packed {
      logic sens_uv;
      logic sens_ovl;
      logic act_uv;
      logic act_short;
      logic out_ovl;
      logic out_short;
   } dio_iostat_type;

endpackage

//--- dio_top.sv
// Overview of operation
// R1: Inputs one to eight fill bits zero-seven.
// R2: Outputs one to four from bits zero-three.
// R3: Status word holds six fault bits, rest reserved.
// R4: Emergency message: code, register, five diag bytes.
// R5: Emergency messages sent unprompted, never confirmed.
// R6: Supply codes 3001-3005, temperature code 4001.
// R7: Clearing sends code zero, clears register bit.
// R8: Update on cycle tick or SYNC0.
// R9: Free-running cycle timing is the default.
// R10: Outputs applied fixed delay after SYNC0.
// R11: Inputs sampled fixed delay after SYNC0.
// R12: New timing mode taken only at restart.
// R13: Restore request acts only at next power-up.
// R14: Watchdog timeout drives safe output values.
// R15: Firmware image accepted through data register.
// R16: Ready indicator steady or flashing after boot.
// R17: Multi-byte data carried least byte first.
// R18: One message per fault edge, no repeats.
`include "dio_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dio_top #(
   parameter int FREE_CYC = `DIO_FREE_CYCLE_NS / `DIO_CLK_NS,
   parameter int WDOG_CYC = `DIO_WDOG_MS * 1000000 / `DIO_CLK_NS,
   parameter int BOOT_CYC = `DIO_BOOT_MS * 1000000 / `DIO_CLK_NS,
   parameter int BLINK_CYC = `DIO_BLINK_MS * 1000000 / `DIO_CLK_NS,
   parameter int N_IN = 8,
   parameter int N_OUT = 4,
   parameter int N_EMCY = 6
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Field pins
   input wire logic [N_IN-1:0] digital_input_channel_i,
   output logic [N_OUT-1:0] digital_output_channel_o,
   input wire dio_pkg::dio_iostat_type iostat_i,
   input wire logic [N_EMCY-1:0] emcy_fault_i,
   input wire logic sync0_i,
   // Emergency message stream, no handshake
   output dio_pkg::dio_emcy_type emcy_msg_o,
   output logic emcy_valid_o,
   // Firmware data stream
   output logic [31:0] fw_data_o,
   output logic fw_valid_o,
   // Indicators and interrupt
   output logic led_ready_o,
   output logic restore_pending_o,
   output logic irq_o
);

   // Emergency message for source idx at fault level lvl
   function automatic dio_pkg::dio_emcy_type emcy_build(
      input logic [2:0] idx,
      input logic lvl,
      input logic [N_EMCY-1:0] flt
   );
      dio_pkg::dio_emcy_type m;
      m = '0;
      m.diag[15:8] = {5'h00, 3'(idx + 3'h1)}; // see R6
      m.err_reg[`DIO_ERRREG_SUPPLY] = |flt[4:0];
      m.err_reg[`DIO_ERRREG_TEMP] = flt[5];
      if (!lvl) begin
         m.code = `DIO_EMCY_CLEAR; // see R7
      end else if (idx == 3'h5) begin
         m.code = `DIO_EMCY_TEMP;
      end else begin
         m.code = `DIO_EMCY_SUPPLY_BASE + 16'(idx + 3'h1);
      end
      return m; // see R4
   endfunction

   // Bus state
   logic aw_full, w_full, wr_go, rd_go;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] next_rdata;
   logic next_rerr, wr_err;
   // Software registers
   logic [7:0] out_img, in_img;
   logic [2:0] ctrl;
   logic [N_OUT-1:0] safe_val;
   logic [15:0] out_dly, in_dly;
   logic [31:0] fw_count;
   logic [2:0] irq_stat, irq_mask, irq_set;
   dio_pkg::dio_emcy_type last_emcy;
   // Block state
   dio_pkg::dio_mode_type mode;
   logic [N_OUT-1:0] out_apply;
   logic safe_act, ready, blink;
   logic [31:0] free_cnt, wdog_cnt, boot_cnt, blink_cnt;
   logic free_tick;
   logic [15:0] ocnt, icnt;
   logic oarm, iarm, o_fire, i_fire;
   logic [N_EMCY-1:0] flt_q, pend;
   logic [2:0] sel;
   logic sel_ok;

   // Write and read handshake decode
   assign wr_go = aw_full && w_full && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // Write address and data captured in either order
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_go) begin
            aw_full <= 1'b0;
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_go) begin
            w_full <= 1'b0;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Unmapped or read-only write addresses
   always_comb begin
      case (aw_addr)
         `DIO_REG_OUTPUT, `DIO_REG_CTRL, `DIO_REG_SAFE,
         `DIO_REG_OUT_DLY, `DIO_REG_IN_DLY, `DIO_REG_RESTORE,
         `DIO_REG_FW_DATA, `DIO_REG_IRQ_STAT,
         `DIO_REG_IRQ_MASK: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   // Write response
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software writes; full words are little-endian, byte 0 at lane 0
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_img <= 8'h00;
         ctrl <= 3'h0;
         safe_val <= `DIO_SAFE_RST;
         out_dly <= `DIO_DLY_RST;
         in_dly <= `DIO_DLY_RST;
         irq_mask <= 3'h0;
         restore_pending_o <= 1'b0;
      end else begin
         ctrl[`DIO_CTRL_RESTART] <= 1'b0;
         if (wr_go && w_strb[0]) begin
            case (aw_addr)
               `DIO_REG_OUTPUT: out_img <= w_data[7:0];
               `DIO_REG_CTRL: ctrl <= w_data[2:0];
               `DIO_REG_SAFE: safe_val <= w_data[N_OUT-1:0];
               `DIO_REG_IRQ_MASK: irq_mask <= w_data[2:0];
               default: ;
            endcase
         end
         if (wr_go && aw_addr == `DIO_REG_OUT_DLY) begin
            out_dly <= w_data[15:0];
         end
         if (wr_go && aw_addr == `DIO_REG_IN_DLY) begin
            in_dly <= w_data[15:0];
         end
         // Held until power cycles; settings stay live meanwhile
         if (wr_go && aw_addr == `DIO_REG_RESTORE &&
             w_data == `DIO_RESTORE_KEY) begin
            restore_pending_o <= 1'b1; // see R13
         end
      end
   end

   // Timing mode switches only on a restart strobe
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode <= dio_pkg::DIO_MODE_SM; // see R9
      end else if (ctrl[`DIO_CTRL_RESTART]) begin
         mode <= ctrl[`DIO_CTRL_DC_REQ] ? dio_pkg::DIO_MODE_DC
                                        : dio_pkg::DIO_MODE_SM; // see R12
      end
   end

   // Free-running cycle divider
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         free_cnt <= 32'h0000_0000;
         free_tick <= 1'b0;
      end else if (free_cnt >= 32'(FREE_CYC - 1)) begin
         free_cnt <= 32'h0000_0000;
         free_tick <= 1'b1;
      end else begin
         free_cnt <= free_cnt + 32'h0000_0001;
         free_tick <= 1'b0;
      end
   end

   // Output and input delay timers after SYNC0
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ocnt <= 16'h0000;
         icnt <= 16'h0000;
         oarm <= 1'b0;
         iarm <= 1'b0;
      end else if (mode == dio_pkg::DIO_MODE_DC && sync0_i) begin
         ocnt <= out_dly; // see R10
         icnt <= in_dly; // see R11
         oarm <= 1'b1;
         iarm <= 1'b1;
      end else begin
         if (oarm) begin
            ocnt <= ocnt - 16'h0001;
         end
         if (oarm && ocnt == 16'h0000) begin
            oarm <= 1'b0;
         end
         if (iarm) begin
            icnt <= icnt - 16'h0001;
         end
         if (iarm && icnt == 16'h0000) begin
            iarm <= 1'b0;
         end
      end
   end

   // Update strobes for the selected timing
   always_comb begin
      if (mode == dio_pkg::DIO_MODE_DC) begin
         o_fire = oarm && ocnt == 16'h0000;
         i_fire = iarm && icnt == 16'h0000;
      end else begin
         o_fire = free_tick; // see R8
         i_fire = free_tick;
      end
   end

   // Input image and applied output image
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_img <= 8'h00;
         out_apply <= '0;
      end else begin
         if (i_fire) begin
            in_img <= 8'(digital_input_channel_i); // see R1
         end
         if (o_fire) begin
            out_apply <= out_img[N_OUT-1:0]; // see R2
         end
      end
   end

   // Communication watchdog, kicked by output image writes
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wdog_cnt <= 32'h0000_0000;
         safe_act <= 1'b0;
      end else if (wr_go && aw_addr == `DIO_REG_OUTPUT) begin
         wdog_cnt <= 32'h0000_0000;
         safe_act <= 1'b0;
      end else if (ctrl[`DIO_CTRL_BUS_OP] && !safe_act) begin
         if (wdog_cnt >= 32'(WDOG_CYC - 1)) begin
            safe_act <= 1'b1; // see R14
         end else begin
            wdog_cnt <= wdog_cnt + 32'h0000_0001;
         end
      end
   end

   // Output pins, safe values win over process data
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         digital_output_channel_o <= '0;
      end else begin
         digital_output_channel_o <= safe_act ? safe_val : out_apply;
      end
   end

   // Lowest pending emergency source
   always_comb begin
      sel = 3'h0;
      sel_ok = 1'b0;
      for (int k = N_EMCY - 1; k >= 0; k--) begin
         if (pend[k]) begin
            sel = 3'(k);
            sel_ok = 1'b1;
         end
      end
   end

   // Edge detection and pending messages per fault source
   for (genvar g = 0; g < N_EMCY; g++) begin : g_emcy
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            flt_q[g] <= 1'b0;
            pend[g] <= 1'b0;
         end else begin
            flt_q[g] <= emcy_fault_i[g];
            if (flt_q[g] != emcy_fault_i[g]) begin
               pend[g] <= 1'b1; // see R18
            end else if (sel_ok && sel == 3'(g)) begin
               pend[g] <= 1'b0;
            end
         end
      end
   end

   // Message emission, one per cycle, no acknowledge awaited
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         emcy_msg_o <= '0;
         emcy_valid_o <= 1'b0;
         last_emcy <= '0;
      end else begin
         emcy_valid_o <= sel_ok; // see R5
         if (sel_ok) begin
            emcy_msg_o <= emcy_build(sel, flt_q[sel], flt_q); // see R17
            last_emcy <= emcy_build(sel, flt_q[sel], flt_q);
         end
      end
   end

   // Firmware data words forwarded as written
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fw_data_o <= 32'h0000_0000;
         fw_valid_o <= 1'b0;
         fw_count <= 32'h0000_0000;
      end else begin
         fw_valid_o <= wr_go && aw_addr == `DIO_REG_FW_DATA;
         if (wr_go && aw_addr == `DIO_REG_FW_DATA) begin
            fw_data_o <= w_data; // see R15
            fw_count <= fw_count + 32'h0000_0001;
         end
      end
   end

   // Boot timer and ready indicator blink
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         boot_cnt <= 32'h0000_0000;
         ready <= 1'b0;
         blink_cnt <= 32'h0000_0000;
         blink <= 1'b0;
         led_ready_o <= 1'b0;
      end else begin
         if (!ready) begin
            boot_cnt <= boot_cnt + 32'h0000_0001;
            ready <= boot_cnt >= 32'(BOOT_CYC - 1);
         end
         if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
            blink_cnt <= 32'h0000_0000;
            blink <= !blink;
         end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
         end
         led_ready_o <= ready &&
                        (ctrl[`DIO_CTRL_BUS_OP] || blink); // see R16
      end
   end

   // Interrupt events; a set wins over a clear
   assign irq_set = {o_fire && mode == dio_pkg::DIO_MODE_DC,
                     wdog_cnt >= 32'(WDOG_CYC - 1) && !safe_act &&
                     ctrl[`DIO_CTRL_BUS_OP], sel_ok};
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_stat <= 3'h0;
         irq_o <= 1'b0;
      end else begin
         if (wr_go && aw_addr == `DIO_REG_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~w_data[2:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // Read data selection
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;
      case (s_axi_araddr)
         `DIO_REG_INPUT: next_rdata = {24'h00_0000, in_img};
         `DIO_REG_OUTPUT: next_rdata = {24'h00_0000, out_img};
         `DIO_REG_IOSTAT: next_rdata = 32'(iostat_i); // see R3
         `DIO_REG_CTRL: next_rdata = {29'h0000_0000, ctrl};
         `DIO_REG_STATUS: next_rdata = {16'h0000, last_emcy.err_reg,
            4'h0, restore_pending_o, ready, safe_act, mode};
         `DIO_REG_SAFE: next_rdata = 32'(safe_val);
         `DIO_REG_OUT_DLY: next_rdata = {16'h0000, out_dly};
         `DIO_REG_IN_DLY: next_rdata = {16'h0000, in_dly};
         `DIO_REG_RESTORE: next_rdata = 32'(restore_pending_o);
         `DIO_REG_FW_COUNT: next_rdata = fw_count;
         `DIO_REG_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
         `DIO_REG_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
         `DIO_REG_EMCY_LO: next_rdata = last_emcy[31:0];
         `DIO_REG_EMCY_HI: next_rdata = last_emcy[63:32];
         default: next_rerr = 1'b1;
      endcase
   end

   // Read channel
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

`default_nettype wire

//--- dio_top_test.sv
`include "dio_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
   err_count++; $display("wrong value %s expected %h seen %h", \
   nm, ex, gt); end end

module dio_top_test;
   localparam int FREE = 100;
   localparam int WD = 300;
   localparam int BT = 20;
   localparam int BL = 8;
   logic clk_i, rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, sync0_i;
   logic emcy_valid_o, fw_valid_o, led_ready_o, restore_pending_o, irq_o;
   logic [7:0] s_axi_awaddr, s_axi_araddr, digital_input_channel_i;
   logic [7:0] pcnt, c0;
   logic [31:0] s_axi_wdata, s_axi_rdata, fw_data_o, rd, fwv, fw_last;
   logic [3:0] s_axi_wstrb, digital_output_channel_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [5:0] emcy_fault_i;
   logic [15:0] seed;
   dio_pkg::dio_iostat_type iostat_i;
   dio_pkg::dio_emcy_type emcy_msg_o, pmsg;
   int err_count, n_checks;

   dio_top #(.FREE_CYC(FREE), .WDOG_CYC(WD), .BOOT_CYC(BT),
      .BLINK_CYC(BL)) u_dio_top (
      .clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .digital_input_channel_i,
      .digital_output_channel_o, .iostat_i, .emcy_fault_i, .sync0_i,
      .emcy_msg_o, .emcy_valid_o, .fw_data_o, .fw_valid_o, .led_ready_o,
      .restore_pending_o, .irq_o);

   dio_master_model u_dio_master_model (.clk_i, .rstn_i,
      .msg_i(emcy_msg_o), .valid_i(emcy_valid_o), .last_o(pmsg),
      .count_o(pcnt));

   // Clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Firmware words seen on the stream
   always @(posedge clk_i) begin
      if (fw_valid_o) begin
         fw_last <= fw_data_o;
      end
   end

   // Random source and expected codes
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] exp_code(input int i);
      return (i == 5) ? 16'h4001 : 16'h3001 + 16'(i);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (!aw && !w && s_axi_bvalid) break;
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_i);
   endtask

   // Bus read
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge clk_i);
      while (!s_axi_arready) @(posedge clk_i);
      s_axi_arvalid <= 1'b0;
      @(posedge clk_i);
      while (!s_axi_rvalid) @(posedge clk_i);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard
   initial begin
      tick(12000);
      err_count++;
      final_report;
   end

   // Main sequence
   initial begin
      {rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, sync0_i} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      {digital_input_channel_i, iostat_i, emcy_fault_i} = 20'h0_0000;
      s_axi_wstrb = 4'hF;
      seed = 16'h0DD2;
      err_count = 0;
      n_checks = 0;
      tick(5);
      rstn_i <= 1'b1;
      tick(2);
      `CHK("led at boot", 1'b0, led_ready_o)
      rdr(`DIO_REG_STATUS);
      `CHK("mode after reset", 1'b0, rd[0])
      rdr(8'h3C);
      `CHK("unmapped read", 2'b10, rs)
      wr(`DIO_REG_INPUT, 32'h0000_00FF);
      `CHK("read-only write", 2'b10, rs)
      // Image traffic in free-running mode
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         if (k == 0) seed = 16'hBF01;
         digital_input_channel_i <= seed[7:0];
         iostat_i <= seed[13:8];
         wr(`DIO_REG_OUTPUT, {24'h00_0000, seed[15:8]});
         tick(FREE + 4);
         `CHK("outputs", seed[11:8], digital_output_channel_o)
         rdr(`DIO_REG_INPUT);
         `CHK("inputs", {24'h00_0000, seed[7:0]}, rd)
         rdr(`DIO_REG_IOSTAT);
         `CHK("io status", {26'h000_0000, seed[13:8]}, rd)
      end
      // Each fault raised then cleared
      wr(`DIO_REG_IRQ_MASK, 32'h0000_0001);
      for (int i = 0; i < 6; i++) begin
         c0 = pcnt;
         emcy_fault_i[i] <= 1'b1;
         tick(8);
         `CHK("count", c0 + 8'h01, pcnt)
         `CHK("code", exp_code(i), pmsg.code)
         `CHK("errreg", (i == 5) ? 8'h10 : 8'h04, pmsg.err_reg)
         `CHK("diag", 40'(i + 1) << 8, pmsg.diag)
         `CHK("irq", 1'b1, irq_o)
         rdr(`DIO_REG_EMCY_LO);
         `CHK("low word", {8'h00, pmsg.err_reg, exp_code(i)}, rd)
         emcy_fault_i[i] <= 1'b0;
         tick(8);
         `CHK("count", c0 + 8'h02, pcnt)
         `CHK("clear code", 16'h0000, pmsg.code)
         `CHK("clear errreg", 8'h00, pmsg.err_reg)
         `CHK("diag kept", 40'(i + 1) << 8, pmsg.diag)
      end
      wr(`DIO_REG_IRQ_MASK, 32'h0000_0000);
      tick(2);
      `CHK("masked irq", 1'b0, irq_o)
      wr(`DIO_REG_IRQ_STAT, 32'h0000_0007);
      wr(`DIO_REG_IRQ_MASK, 32'h0000_0001);
      tick(2);
      `CHK("cleared irq", 1'b0, irq_o)
      // Firmware word
      seed = lfsr(seed);
      fwv = {seed, ~seed};
      wr(`DIO_REG_FW_DATA, fwv);
      tick(3);
      `CHK("fw word", fwv, fw_last)
      // Link loss while operational, then recovery
      wr(`DIO_REG_SAFE, 32'h0000_0005);
      wr(`DIO_REG_CTRL, 32'h0000_0004);
      wr(`DIO_REG_OUTPUT, 32'h0000_000A);
      tick(FREE + 4);
      `CHK("live outputs", 4'hA, digital_output_channel_o)
      tick(WD + FREE + 10);
      `CHK("safe outputs", 4'h5, digital_output_channel_o)
      `CHK("ready lit", 1'b1, led_ready_o)
      tick(BL + 1);
      `CHK("ready steady", 1'b1, led_ready_o)
      wr(`DIO_REG_OUTPUT, 32'h0000_000A);
      tick(FREE + 4);
      `CHK("outputs back", 4'hA, digital_output_channel_o)
      wr(`DIO_REG_CTRL, 32'h0000_0000);
      c0[0] = led_ready_o;
      tick(BL);
      `CHK("ready blinks", ~c0[0], led_ready_o)
      // Timing mode change only through restart
      wr(`DIO_REG_CTRL, 32'h0000_0001);
      rdr(`DIO_REG_STATUS);
      `CHK("mode held", 1'b0, rd[0])
      wr(`DIO_REG_CTRL, 32'h0000_0003);
      wr(`DIO_REG_OUT_DLY, 32'h0000_000A);
      wr(`DIO_REG_IN_DLY, 32'h0000_0005);
      rdr(`DIO_REG_STATUS);
      `CHK("mode switched", 1'b1, rd[0])
      seed = lfsr(seed);
      c0 = digital_input_channel_i;
      digital_input_channel_i <= seed[7:0];
      wr(`DIO_REG_OUTPUT, 32'h0000_0006);
      tick(2 * FREE);
      `CHK("no free out", 4'hA, digital_output_channel_o)
      rdr(`DIO_REG_INPUT);
      `CHK("no free in", {24'h00_0000, c0}, rd)
      sync0_i <= 1'b1;
      @(posedge clk_i);
      sync0_i <= 1'b0;
      tick(12);
      `CHK("before delay", 4'hA, digital_output_channel_o)
      tick(1);
      `CHK("after delay", 4'h6, digital_output_channel_o)
      rdr(`DIO_REG_INPUT);
      `CHK("synced in", {24'h00_0000, seed[7:0]}, rd)
      // Restore request waits for the next power-up
      wr(`DIO_REG_RESTORE, 32'h0000_0001);
      tick(1);
      `CHK("restore flag", 1'b1, restore_pending_o)
      rdr(`DIO_REG_STATUS);
      `CHK("settings kept", 1'b1, rd[0])
      rstn_i <= 1'b0;
      tick(5);
      rstn_i <= 1'b1;
      tick(2);
      `CHK("restore done", 1'b0, restore_pending_o)
      rdr(`DIO_REG_STATUS);
      `CHK("default mode", 1'b0, rd[0])
      final_report;
   end
endmodule

bind dio_top dio_checker #(.BOOT_CYC(BOOT_CYC)) u_dio_checker (
   .clk_i, .rstn_i, .emcy_fault_i, .emcy_msg_o, .emcy_valid_o,
   .led_ready_o);

`default_nettype wire
